//--- src/ocr_pkg.sv
/*
 option configuration register bank: offsets, field positions, reset
 values, timing counts and the packed carrier types.
 assumes a single 25 mhz bus clock and a one-slave ahb-lite bus.
*/
package ocr_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [7:0] OCR_OFS_LATCH_A = 8'h1f;
    localparam logic [7:0] OCR_OFS_LATCH_B = 8'h1d;
    localparam logic [7:0] OCR_OFS_OPTION  = 8'h20;
    localparam logic [7:0] OCR_OFS_STATUS  = 8'h24;
    localparam logic [7:0] OCR_OFS_OPT_PGM = 8'h28;
    localparam logic [7:0] OCR_OFS_STOP    = 8'h2c;
    // latch a field positions
    localparam int OCR_A_WDOG_DIS   = 0;
    localparam int OCR_A_STOP_EN    = 1;
    localparam int OCR_A_SHORT_REC  = 2;
    localparam int OCR_A_MODE_SEL   = 3;
    localparam int OCR_A_PWR_DIS    = 4;
    localparam int OCR_A_RST_DIS    = 5;
    localparam int OCR_A_STOP_LVM   = 6;
    localparam int OCR_A_WDOG_RATE  = 7;
    // latch b field positions
    localparam int OCR_B_SER_CLK    = 0;
    localparam int OCR_B_CD_OE      = 1;
    localparam int OCR_B_TB_LO      = 2;
    localparam int OCR_B_TB_HI      = 3;
    localparam int OCR_B_CRYSTAL_CLOCK_STOP  = 4;
    localparam int OCR_B_RC_STOP    = 5;
    localparam int OCR_B_INT_STOP   = 6;
    // option byte field positions
    localparam int OCR_O_SEL_LO     = 6;
    localparam int OCR_O_SEL_HI     = 7;
    // reset / erased values
    localparam logic [7:0] OCR_LATCH_RST  = 8'h00;
    localparam logic [7:0] OCR_OPT_ERASED = 8'hff;
    // stop recovery: cycles of the bus clock
    localparam int unsigned OCR_REC_SHORT = 32;
    localparam int unsigned OCR_REC_LONG  = 4096;
    // bus size code for a word
    localparam logic [2:0] OCR_HSIZE_WORD = 3'h2;
    // timebase and reference clock encodings
    typedef enum logic [1:0] {
        OCR_TB_INT  = 2'h0,
        OCR_TB_RC   = 2'h1,
        OCR_TB_CRYSTAL_CLOCK = 2'h2,
        OCR_TB_NONE = 2'h3
    } ocr_tb_src_t;
    // outgoing control bundle
    typedef struct packed {
        logic lvm_reset_pass;
        logic lvm_power_on;
        logic lvm_mode_5v;
        logic lvm_stop_enable;
        logic stop_legal;
        logic watchdog_enable;
        logic watchdog_fast;
        logic int_osc_run_stop;
        logic rc_osc_run_stop;
        logic crystal_clock_osc_run_stop;
        logic [1:0] timebase_src;
        logic cd_pin_enable;
        logic serial_clk_bus;
        logic [1:0] ref_clk_sel;
        logic second_osc_pin_inverted_crystal_clock;
        logic int_osc_available;
    } ocr_ctrl_t;
endpackage

//--- src/ocr_regs.sv
/*
 write-once option latches, a flash-held clock option byte and the
 stop-recovery delay counter, behind an ahb-lite slave.
 assumes one bus master, single word transfers, the flash side handing
 a programmed byte over as a one-cycle strobe, and hclk at 25 mhz.
*/
// Implementation choices: the placing of the registers and register access over AHB-Lite.
// Summary of operation
// - low-voltage reset disable set blocks monitor resets; clear passes them
// - low-voltage power disable set powers the monitor down
// - mode select set gives 5v trip mode, clear gives 3v
// - stop exit waits 32 cycles with short recovery set, else 4096
// - stop exit through the reset pin always uses the long delay
// - stop enable clear makes the stop instruction illegal
// - watchdog disable set turns the watchdog off
// - internal oscillator stop control set halts it in stop; reset clears
// - rc stop enable set keeps rc running in stop; reset clears
// - crystal stop enable set keeps crystal running in stop; reset clears
// - timebase source field: internal, rc, crystal, unused; reset clears
// - current-detect enable routes the flag to the shared pin
// - serial clock select: bus clock when set, reference clock when clear
// - oscillator select chooses reference clock and second pin function
// - oscillator select erases to one, set only by programming, keeps
// - internal oscillator runs and is available after every reset
// - each latch register takes only the first write after reset
// - reset clears latches except mode select, cleared by power-on only
// - mode select takes one write only after a power-on reset
module ocr_regs
(
    // bus clock and resets
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              por_n,
    // ahb-lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // flash programming of the option byte
    input  wire logic              opt_pgm_stb,
    input  wire logic [7:0]        opt_pgm_data,
    // stop mode and monitor events
    input  wire logic              stop_exit_req,
    input  wire logic              stop_exit_by_pin,
    input  wire logic              lvm_reset_req,
    input  wire logic              current_detect_flag,
    // controls
    output ocr_pkg::ocr_ctrl_t     ctrl,
    output logic                   lvm_reset_out,
    output logic                   current_detect_output,
    output logic                   stop_recovering,
    output logic                   stop_recovered
);
    import ocr_pkg::*;

    logic [7:0]  latch_a_r;
    logic [7:0]  latch_b_r;
    logic [7:0]  opt_r;
    logic        a_written_r;
    logic        b_written_r;
    logic        mode_written_r;
    logic        mode_sel_r;
    logic        wr_pend_r;
    logic [7:0]  addr_r;
    logic [12:0] rec_cnt_r;
    logic [12:0] rec_cnt_nxt;
    logic        addr_ok;
    logic        wr_a;
    logic        wr_b;
    logic [7:0]  rd_mux;

    // address phase taken on any valid transfer; hsize is not checked
    assign addr_ok = hsel && hready && htrans[1];
    assign wr_a = wr_pend_r && (addr_r == OCR_OFS_LATCH_A);
    assign wr_b = wr_pend_r && (addr_r == OCR_OFS_LATCH_B);

    // capture address phase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end
        else
        begin
            wr_pend_r <= addr_ok && hwrite;
            if (addr_ok)
                addr_r <= haddr[9:2];   // word index of the register
        end
    end

    // latch a, first write only; mode select bit kept separately
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_a_r   <= OCR_LATCH_RST;
            a_written_r <= 1'b0;
        end
        else if (wr_a && !a_written_r)
        begin
            latch_a_r   <= hwdata[7:0];
            a_written_r <= 1'b1;
        end
    end

    // mode select survives ordinary reset, one write per power-on
    always_ff @(posedge hclk or negedge por_n)
    begin
        if (!por_n)
        begin
            mode_sel_r     <= 1'b0;
            mode_written_r <= 1'b0;
        end
        else if (wr_a && !mode_written_r)
        begin
            mode_sel_r     <= hwdata[OCR_A_MODE_SEL];
            mode_written_r <= 1'b1;
        end
    end

    // latch b, first write only
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            latch_b_r   <= OCR_LATCH_RST;
            b_written_r <= 1'b0;
        end
        else if (wr_b && !b_written_r)
        begin
            latch_b_r   <= {1'b0, hwdata[6:0]};
            b_written_r <= 1'b1;
        end
    end

    // option byte: erased state at power-on, only programming changes it
    always_ff @(posedge hclk or negedge por_n)
    begin
        if (!por_n)
            opt_r <= OCR_OPT_ERASED;
        else if (opt_pgm_stb)
            opt_r <= opt_r & opt_pgm_data;  // programming only clears
    end

    // stop recovery counter load and count down
    always_comb
    begin
        rec_cnt_nxt = rec_cnt_r;
        if (stop_exit_req)
        begin
            if (latch_a_r[OCR_A_SHORT_REC] && !stop_exit_by_pin)
                rec_cnt_nxt = 13'(OCR_REC_SHORT);
            else
                rec_cnt_nxt = 13'(OCR_REC_LONG);
        end
        else if (rec_cnt_r != 13'h0000)
            rec_cnt_nxt = rec_cnt_r - 13'h0001;
    end

    // recovery counter and its flags
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rec_cnt_r       <= 13'h0000;
            stop_recovering <= 1'b0;
            stop_recovered  <= 1'b0;
        end
        else
        begin
            rec_cnt_r       <= rec_cnt_nxt;
            stop_recovering <= rec_cnt_nxt != 13'h0000;
            stop_recovered  <= (rec_cnt_r == 13'h0001) && !stop_exit_req;
        end
    end

    // registered control outputs
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            // controls as cleared latches give them; the internal
            // oscillator stays available straight through reset
            ctrl                  <= '{lvm_reset_pass:    1'b1,
                                       lvm_power_on:      1'b1,
                                       watchdog_enable:   1'b1,
                                       int_osc_run_stop:  1'b1,
                                       int_osc_available: 1'b1,
                                       default:           '0};
            lvm_reset_out         <= 1'b0;
            current_detect_output <= 1'b0;
        end
        else
        begin
            ctrl.lvm_reset_pass    <= !latch_a_r[OCR_A_RST_DIS];
            ctrl.lvm_power_on      <= !latch_a_r[OCR_A_PWR_DIS];
            ctrl.lvm_mode_5v       <= mode_sel_r;
            ctrl.lvm_stop_enable   <= latch_a_r[OCR_A_STOP_LVM]
                                      && !latch_a_r[OCR_A_PWR_DIS];
            ctrl.stop_legal        <= latch_a_r[OCR_A_STOP_EN];
            ctrl.watchdog_enable   <= !latch_a_r[OCR_A_WDOG_DIS];
            ctrl.watchdog_fast     <= latch_a_r[OCR_A_WDOG_RATE];
            ctrl.int_osc_run_stop  <= !latch_b_r[OCR_B_INT_STOP];
            ctrl.rc_osc_run_stop   <= latch_b_r[OCR_B_RC_STOP];
            ctrl.crystal_clock_osc_run_stop <= latch_b_r[OCR_B_CRYSTAL_CLOCK_STOP];
            ctrl.timebase_src      <= latch_b_r[OCR_B_TB_HI:OCR_B_TB_LO];
            ctrl.cd_pin_enable     <= latch_b_r[OCR_B_CD_OE];
            ctrl.serial_clk_bus    <= latch_b_r[OCR_B_SER_CLK];
            ctrl.ref_clk_sel       <= opt_r[OCR_O_SEL_HI:OCR_O_SEL_LO];
            ctrl.second_osc_pin_inverted_crystal_clock <= &opt_r[OCR_O_SEL_HI:OCR_O_SEL_LO];
            ctrl.int_osc_available <= 1'b1;
            lvm_reset_out          <= lvm_reset_req
                                      && !latch_a_r[OCR_A_RST_DIS];
            current_detect_output  <= current_detect_flag
                                      && latch_b_r[OCR_B_CD_OE];
        end
    end

    // read data mux on the address phase index, unmapped reads zero
    always_comb
    begin
        case (haddr[9:2])
            OCR_OFS_LATCH_A:
                rd_mux = {latch_a_r[7:4], mode_sel_r, latch_a_r[2:0]};
            OCR_OFS_LATCH_B: rd_mux = latch_b_r;
            OCR_OFS_OPTION:  rd_mux = opt_r;
            OCR_OFS_STATUS:
                rd_mux = {4'h0, stop_recovering, mode_written_r,
                          b_written_r, a_written_r};
            default:         rd_mux = 8'h00;
        endcase
    end

    // bus answer: zero wait, always okay; read data is launched from the
    // address phase so it stands for the whole data phase. a read whose
    // address is taken on the edge a write lands sees the old value
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata    <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (addr_ok && !hwrite)
                hrdata <= {24'h000000, rd_mux};
            else
                hrdata <= 32'h0000_0000;
        end
    end

    // the delay loaded on a stop exit, and the last step of the count
    sequence rec_short_exit_s;
        stop_exit_req && latch_a_r[OCR_A_SHORT_REC] && !stop_exit_by_pin;
    endsequence
    sequence rec_long_exit_s;
        stop_exit_req && (!latch_a_r[OCR_A_SHORT_REC] || stop_exit_by_pin);
    endsequence
    sequence rec_last_step_s;
        (rec_cnt_r == 13'h0001) && !stop_exit_req;
    endsequence

    // short recovery loads the short count
    AST_SHORT_REC: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rec_short_exit_s |=> rec_cnt_r == 13'(OCR_REC_SHORT))
        else $error("short recovery count wrong");
    // any other exit loads the long count
    AST_LONG_REC: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rec_long_exit_s |=> rec_cnt_r == 13'(OCR_REC_LONG))
        else $error("long recovery count wrong");
    // a pin exit never takes the short count
    AST_PIN_LONG: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stop_exit_req && stop_exit_by_pin |=> rec_cnt_r == 13'd4096)
        else $error("pin exit not long");
    // the count ends in the recovered pulse
    AST_REC_DONE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        rec_last_step_s |=> stop_recovered && (rec_cnt_r == 13'h0000))
        else $error("recovered pulse missing at count end");
    // the recovered pulse lasts one cycle
    AST_REC_PULSE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        stop_recovered |=> !stop_recovered)
        else $error("recovered pulse too long");
    // latch a holds after its first write
    AST_FIRST_WRITE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        a_written_r |=> $stable(latch_a_r))
        else $error("latch a changed after first write");
    // latch b holds after its first write
    AST_B_ONCE: assert property (
        @(posedge hclk) disable iff (!hresetn)
        b_written_r |=> $stable(latch_b_r))
        else $error("latch b changed after first write");
    // monitor resets blocked while disabled
    AST_LVM_RST: assert property (
        @(posedge hclk) disable iff (!hresetn)
        latch_a_r[OCR_A_RST_DIS] && $stable(latch_a_r) |=> !lvm_reset_out)
        else $error("monitor reset not blocked");
    // option byte moves only on a programming strobe
    AST_OPT_KEEP: assert property (
        @(posedge hclk) disable iff (!por_n)
        !opt_pgm_stb |=> $stable(opt_r))
        else $error("option byte changed without programming");
    // mode select takes one write per power-on
    AST_MODE_ONCE: assert property (
        @(posedge hclk) disable iff (!por_n)
        mode_written_r |=> $stable(mode_sel_r))
        else $error("mode select rewritten");
    // current-detect pin only while enabled
    AST_CD_PIN: assert property (
        @(posedge hclk) disable iff (!hresetn)
        current_detect_output |-> $past(latch_b_r[OCR_B_CD_OE]))
        else $error("current detect out while disabled");
    // stop instruction illegal while its enable is clear
    AST_STOP_ILLEGAL: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !latch_a_r[OCR_A_STOP_EN] && $stable(latch_a_r) |=> !ctrl.stop_legal)
        else $error("stop legal while disabled");
    // watchdog off while its disable is set
    AST_WDOG_OFF: assert property (
        @(posedge hclk) disable iff (!hresetn)
        latch_a_r[OCR_A_WDOG_DIS] && $stable(latch_a_r)
        |=> !ctrl.watchdog_enable)
        else $error("watchdog enabled while disabled");
    // internal oscillator halts in stop when asked
    AST_INT_OSC_HALT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        latch_b_r[OCR_B_INT_STOP] && $stable(latch_b_r)
        |=> !ctrl.int_osc_run_stop)
        else $error("internal oscillator kept running in stop");
    // an option byte read returns the byte held at the address phase
    AST_READ_OPT: assert property (
        @(posedge hclk) disable iff (!hresetn)
        addr_ok && !hwrite && (haddr[9:2] == OCR_OFS_OPTION)
        |=> hrdata == {24'h000000, $past(opt_r)})
        else $error("option byte read data wrong");
endmodule

//--- test/option_config_registers_tb.sv
/*
 self-checking bench for the option configuration register bank.
 assumes the ocr_regs ports as declared, a 25 mhz hclk, one ahb master.
*/
module option_config_registers_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ocr_pkg::*;

    // printed offsets are word indices, the bus address is four times that
    localparam logic [31:0] ADR_A = {22'h0, OCR_OFS_LATCH_A, 2'h0};
    localparam logic [31:0] ADR_B = {22'h0, OCR_OFS_LATCH_B, 2'h0};
    localparam logic [31:0] ADR_O = {22'h0, OCR_OFS_OPTION, 2'h0};
    localparam logic [31:0] ADR_S = {22'h0, OCR_OFS_STATUS, 2'h0};
    localparam logic [31:0] ADR_X = 32'h0000_00f0;

    logic        hclk, hresetn, por_n, hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        opt_pgm_stb, stop_exit_req, stop_exit_by_pin;
    logic [7:0]  opt_pgm_data;
    logic        lvm_reset_req, current_detect_flag, lvm_reset_out;
    logic        current_detect_output, stop_recovering, stop_recovered;
    ocr_ctrl_t   ctrl;
    logic [7:0]  ea, eb, eo;
    logic        mode_v;
    int          bad_count, checks_done, cycles;

    assign hready = hreadyout;

    ocr_regs u_dut (.hclk(hclk), .hresetn(hresetn), .por_n(por_n),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .opt_pgm_stb(opt_pgm_stb),
        .opt_pgm_data(opt_pgm_data), .stop_exit_req(stop_exit_req),
        .stop_exit_by_pin(stop_exit_by_pin), .lvm_reset_req(lvm_reset_req),
        .current_detect_flag(current_detect_flag), .ctrl(ctrl),
        .lvm_reset_out(lvm_reset_out),
        .current_detect_output(current_detect_output),
        .stop_recovering(stop_recovering), .stop_recovered(stop_recovered));

    // 40 ns bus clock
    initial
    begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end

    // expected control bundle from latch and option contents
    function automatic ocr_ctrl_t exp_ctrl(input logic [7:0] a, b, o);
        ocr_ctrl_t c;
        c.lvm_reset_pass     = ~a[OCR_A_RST_DIS];
        c.lvm_power_on       = ~a[OCR_A_PWR_DIS];
        c.lvm_mode_5v        = a[OCR_A_MODE_SEL];
        c.lvm_stop_enable    = a[OCR_A_STOP_LVM] & ~a[OCR_A_PWR_DIS];
        c.stop_legal         = a[OCR_A_STOP_EN];
        c.watchdog_enable    = ~a[OCR_A_WDOG_DIS];
        c.watchdog_fast      = a[OCR_A_WDOG_RATE];
        c.int_osc_run_stop   = ~b[OCR_B_INT_STOP];
        c.rc_osc_run_stop    = b[OCR_B_RC_STOP];
        c.crystal_clock_osc_run_stop  = b[OCR_B_CRYSTAL_CLOCK_STOP];
        c.timebase_src       = {b[OCR_B_TB_HI], b[OCR_B_TB_LO]};
        c.cd_pin_enable      = b[OCR_B_CD_OE];
        c.serial_clk_bus     = b[OCR_B_SER_CLK];
        c.ref_clk_sel        = o[7:6];
        c.second_osc_pin_inverted_crystal_clock = (o[7:6] == 2'h3);
        c.int_osc_available  = 1'b1;
        return c;
    endfunction

    // closing verdict, the single end of the run
    task automatic final_report;
        if (bad_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        checks_done++;
        if (ok !== 1'b1)
        begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // one single ahb-lite transfer, entered right after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] wd, output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= OCR_HSIZE_WORD;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(hresp === 1'b0, "bus response not okay");
    endtask

    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, {24'h0, d}, rd);
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [7:0] e,
                          input string msg);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        chk(rd[7:0] === e, msg);
    endtask

    // let the latch and the registered controls settle, then compare
    task automatic ctrl_chk;
        repeat (3) @(posedge hclk);
        #1;
        chk(ctrl === exp_ctrl(ea, eb, eo), "control bundle");
        @(posedge hclk);
    endtask

    // random monitor reset requests and current-detect flags
    task automatic gate_chk;
        repeat (8)
        begin
            lvm_reset_req <= 1'($urandom);
            current_detect_flag <= 1'($urandom);
            repeat (3) @(posedge hclk);
            #1;
            chk(lvm_reset_out === (lvm_reset_req & ~ea[OCR_A_RST_DIS]),
                "monitor reset gate");
            chk(current_detect_output ===
                (current_detect_flag & eb[OCR_B_CD_OE]), "cd pin");
            @(posedge hclk);
        end
    endtask

    // stop exit, cycles counted up to the recovered pulse
    task automatic rec(input logic pin, input int n_exp);
        int n;
        int nr;
        n = 0;
        nr = 0;
        stop_exit_by_pin <= pin;
        stop_exit_req <= 1'b1;
        @(posedge hclk);
        stop_exit_req <= 1'b0;
        while (stop_recovered !== 1'b1 && n < 5000)
        begin
            @(posedge hclk);
            n++;
            if (stop_recovering === 1'b1)
                nr++;
        end
        chk(n >= n_exp && n <= n_exp + 2, "recovery length");
        chk(nr == n_exp, "recovering level length");
        stop_exit_by_pin <= 1'b0;
    endtask

    task automatic reset_pulse(input logic por);
        hresetn <= 1'b0;
        por_n <= ~por;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        por_n <= 1'b1;
        @(posedge hclk);
        ea = 8'h00;
        eb = 8'h00;
        ea[OCR_A_MODE_SEL] = por ? 1'b0 : mode_v;
        if (por)
            eo = OCR_OPT_ERASED;
    endtask

    task automatic prog(input logic [7:0] d);
        opt_pgm_data <= d;
        opt_pgm_stb <= 1'b1;
        @(posedge hclk);
        opt_pgm_stb <= 1'b0;
        eo = eo & d;
        ctrl_chk;
        rd_chk(ADR_O, eo, "option byte after programming");
    endtask

    // hang guard
    always @(posedge hclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            $display("mismatch at %0t: run timed out", $time);
            final_report;
        end
    end

    // main sequence
    initial
    begin
        logic [7:0] w1, w2;
        {hresetn, por_n, hsel, hwrite, opt_pgm_stb, stop_exit_req} = 6'h0;
        {stop_exit_by_pin, lvm_reset_req, current_detect_flag} = 3'h0;
        {haddr, hwdata, htrans, hsize, opt_pgm_data} = 77'h0;
        {bad_count, checks_done, cycles, mode_v} = 0;
        void'($urandom(32'h2e7e2bb0));
        repeat (4) @(posedge hclk);
        reset_pulse(1'b1);
        rd_chk(ADR_A, ea, "latch a reset");
        rd_chk(ADR_B, eb, "latch b reset");
        rd_chk(ADR_O, eo, "option erased");
        ctrl_chk;
        // first write sticks, a back-to-back second one is dropped
        w1 = 8'($urandom) | 8'h24;
        wr(ADR_A, w1);
        wr(ADR_A, ~w1);
        w2 = {1'b0, 7'($urandom)} | 8'h12;
        wr(ADR_B, w2);
        wr(ADR_B, ~w2 & 8'h7f);
        ea = w1;
        eb = w2;
        mode_v = w1[OCR_A_MODE_SEL];
        rd_chk(ADR_A, ea, "latch a write once");
        rd_chk(ADR_B, eb, "latch b write once");
        rd_chk(ADR_S, 8'h07, "written flags");
        ctrl_chk;
        gate_chk;
        // option byte is not writable over the bus, unmapped space aliases nothing
        wr(ADR_O, 8'h00);
        wr(ADR_X, 8'h00);
        rd_chk(ADR_O, eo, "option bus write");
        rd_chk(ADR_A, ea, "unmapped write");
        rec(1'b0, OCR_REC_SHORT);
        rec(1'b1, OCR_REC_LONG);
        // plain reset keeps mode select and the option byte
        reset_pulse(1'b0);
        rd_chk(ADR_A, ea, "latch a after reset");
        rd_chk(ADR_B, eb, "latch b after reset");
        w1 = ~w1;
        wr(ADR_A, w1);
        ea = w1;
        ea[OCR_A_MODE_SEL] = mode_v;
        rd_chk(ADR_A, ea, "mode select locked");
        rd_chk(ADR_S, 8'h05, "written flags after reset");
        ctrl_chk;
        gate_chk;
        rec(1'b0, OCR_REC_LONG);
        // oscillator select codes 2, 1 and 0; the erased code 3 is checked at the start
        prog(8'hbf);
        reset_pulse(1'b1);
        prog(8'h7f);
        prog(8'h3f);
        final_report;
    end
endmodule
